/* hw/tms_pkg.sv */
// shared constants for the tunable module serial slave port
package tms_pkg;
	// ************************************************************
	// packet and capability layout
	// ************************************************************
	localparam int          PKT_BITS         = 32;
	localparam int          CAP_WIDTH        = 16;
	localparam int          CAP_RATE_LSB     = 0;
	localparam int          CAP_RATE_BITS    = 6;
	localparam logic [5:0]  CAP_RATE_DEFAULT = 6'h01;
	localparam logic [15:0] CAP_RESET        = 16'h0001;
	localparam int          MIN_RATE_MHZ     = 1;
	localparam int          CORE_CLK_MHZ     = 200;
	// guaranteed link rate gives this many core cycles per shift clock period
	localparam int          MIN_RATE_CYCLES  = CORE_CLK_MHZ / MIN_RATE_MHZ;
	localparam int          BUSY_CYCLES      = 4;
	// interface select encodings (select_1, select_0)
	localparam logic [1:0]  IFSEL_SPI        = 2'b00;
	localparam logic [1:0]  IFSEL_ASYNC      = 2'b01;
	localparam logic [1:0]  IFSEL_VENDOR     = 2'b11;
	typedef enum logic [1:0] {
		TMS_IDLE,
		TMS_SHIFT,
		TMS_FULL,
		TMS_EXEC
	} tms_state_t;
endpackage

/* hw/tms_spi_slave.sv */
// serial peripheral slave port of a tunable module with pacing and alarm lines
//
// Functional notes
// RULE1 - incoming serial bit captured on shift clock rising edge
// RULE2 - outgoing serial bit changes on shift clock falling edge
// RULE3 - host keeps shift clock low when idle, one pulse per bit
// RULE4 - serial output driven only while module select is low
// RULE5 - module select high returns the link logic to its start
// RULE6 - port works at a 1 MHz shift clock
// RULE7 - host starts at 1 MHz or below, then respects reported maximum
// RULE8 - mode pins choose interface; 10 async serial, 11 vendor specific; code maps async to select_1 low, select_0 high
// RULE9 - mode pins sampled only at reset, later changes ignored
// RULE10 - port is a slave only, never drives clock or select
// RULE11 - packets are four bytes with select held low throughout
// RULE12 - select rising before 32 bits aborts and drops the packet
// RULE13 - execution of a complete packet starts when select rises
// RULE14 - host may release select between read command and response
// RULE15 - command done low marks finish; only then read the response
// RULE16 - host may send a no-operation packet to fetch error bits
// RULE17 - errors with requests enabled drive service request low
// RULE18 - service request holds until cleared, reasserts if error persists
// RULE19 - alarm output is non-latching and follows selected condition
// RULE20 - alarm held asserted during tuning when used as lock flag
// RULE21 - capability bits 5:0 max rate in MHz, bits 15:6 zero
// RULE22 - capability returns to default on every reset
// RULE23 - shifting out and in starts as soon as select falls
// RULE24 - slave shift register is 32 bits, host units 8/16/32
// RULE25 - command done high from valid packet end until execution finishes
`timescale 1ns/1ps
`default_nettype none
module tms_spi_slave
	import tms_pkg::*;
#(
	parameter logic [5:0] MAX_RATE_MHZ = CAP_RATE_DEFAULT
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_in,
	// link pins, inputs all from outside the core clock domain
	input  wire logic                 shift_clock_in,
	input  wire logic                 module_select_n_in,
	input  wire logic                 serial_data_in,
	output var  logic                 serial_data_out,
	output var  logic                 serial_data_oe_out,
	input  wire logic                 interface_select_0_in,
	input  wire logic                 interface_select_1_in,
	// pacing and attention pins
	output var  logic                 command_done_n_out,
	output var  logic                 service_request_n_out,
	output var  logic                 condition_flag_n_out,
	// core side: packets in and out
	output var  logic [PKT_BITS-1:0]  rx_packet_out,
	output var  logic                 rx_packet_valid_out,
	input  wire logic [PKT_BITS-1:0]  tx_packet_in,
	input  wire logic                 exec_done_in,
	// error and alarm sources from the command layer
	input  wire logic                 comm_error_flag_in,
	input  wire logic                 exec_error_flag_in,
	input  wire logic                 service_enable_in,
	input  wire logic                 status_clear_in,
	input  wire logic                 alarm_condition_in,
	input  wire logic                 alarm_is_lock_in,
	input  wire logic                 tuning_active_in,
	// interface choice and capability contents
	output var  logic [1:0]           interface_mode_out,
	output var  logic [CAP_WIDTH-1:0] interface_capability_out
);
	initial begin
		if (MAX_RATE_MHZ == 6'h00) $error("maximum rate must be at least 1 MHz");
		if (MIN_RATE_CYCLES < 8) $error("core clock too slow for guaranteed link rate");
		if (BUSY_CYCLES < 1 || BUSY_CYCLES > 8) $error("busy span must fit the three bit counter");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] pins_sync;

	tms_sync #(
		.WIDTH(3)
	) u_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		// select travels active high so the cleared flops read as deselected
		.async_in    ({shift_clock_in, ~module_select_n_in, serial_data_in}),
		.sync_out    (pins_sync)
	);

	wire sclk_s = pins_sync[2];
	wire sel_n_s = ~pins_sync[1]; // idle high out of reset, so no false select edge
	wire mosi_s = pins_sync[0];

	// ************************************************************
	// edge detection on shift clock and select
	// ************************************************************
	logic sclk_prev_q;
	logic sel_n_prev_q;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sclk_prev_q  <= 1'b0;
			sel_n_prev_q <= 1'b1;
		end else begin
			sclk_prev_q  <= sclk_s;
			sel_n_prev_q <= sel_n_s;
		end
	end

	// link idle clock is low, so edges only count while selected
	wire selected   = ~sel_n_s;
	wire sclk_rise  = selected & sclk_s & ~sclk_prev_q;
	wire sclk_fall  = selected & ~sclk_s & sclk_prev_q;
	wire sel_fall   = sel_n_prev_q & ~sel_n_s;
	wire sel_rise   = ~sel_n_prev_q & sel_n_s;

	// ************************************************************
	// mode pin capture after reset release
	// ************************************************************
	logic       mode_taken_q;
	logic [1:0] mode_q;
	logic [1:0] mode_pins_sync;

	tms_sync #(
		.WIDTH(2)
	) u_mode_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.async_in    ({interface_select_1_in, interface_select_0_in}),
		.sync_out    (mode_pins_sync)
	);

	// caught once, a few cycles after release, then frozen
	logic [1:0] mode_wait_q;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			mode_wait_q  <= 2'd0;
			mode_taken_q <= 1'b0;
			mode_q       <= IFSEL_SPI;
		end else if (!mode_taken_q) begin
			mode_wait_q <= mode_wait_q + 2'd1;
			if (mode_wait_q == 2'd3) begin
				mode_taken_q <= 1'b1; // RULE9
				mode_q       <= mode_pins_sync; // RULE8
			end
		end
	end

	// serial port only answers when the straps chose it
	wire spi_mode = mode_taken_q & (mode_q == IFSEL_SPI); // RULE8

	// ************************************************************
	// packet shift register and state machine
	// ************************************************************
	tms_state_t      state_q;
	logic [PKT_BITS-1:0] rx_shift_q;
	logic [PKT_BITS-1:0] tx_shift_q;
	logic [5:0]      bit_cnt_q;
	logic            miso_q;
	logic            oe_q;
	logic [PKT_BITS-1:0] rx_pkt_q;
	logic            rx_valid_q;
	logic            done_n_q;
	logic [2:0]      busy_cnt_q;

	wire packet_full = (bit_cnt_q == 6'd32); // RULE11 RULE24
	wire exec_finish = (state_q == TMS_EXEC) & exec_done_in & (busy_cnt_q == 3'd0);

	// select high resets the link, so a short frame is simply dropped
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_q    <= TMS_IDLE;
			rx_shift_q <= '0;
			tx_shift_q <= '0;
			bit_cnt_q  <= 6'd0;
			miso_q     <= 1'b0;
			rx_pkt_q   <= '0;
			rx_valid_q <= 1'b0;
			busy_cnt_q <= 3'd0;
		end else begin
			rx_valid_q <= 1'b0;
			case (state_q)
				TMS_IDLE, TMS_SHIFT, TMS_FULL: begin
					if (!spi_mode) begin
						state_q <= TMS_IDLE;
					end else if (sel_fall) begin
						// load and present the first bit at once
						tx_shift_q <= {tx_packet_in[PKT_BITS-2:0], 1'b0}; // RULE23
						miso_q     <= tx_packet_in[PKT_BITS-1]; // RULE23
						bit_cnt_q  <= 6'd0;
						state_q    <= TMS_SHIFT;
					end else if (sel_rise) begin
						bit_cnt_q <= 6'd0; // RULE5 RULE12
						if (state_q == TMS_FULL) begin
							rx_pkt_q   <= rx_shift_q;
							rx_valid_q <= 1'b1; // RULE13
							busy_cnt_q <= 3'(BUSY_CYCLES - 1);
							state_q    <= TMS_EXEC;
						end else begin
							state_q <= TMS_IDLE; // RULE12
						end
					end else if (state_q != TMS_IDLE) begin
						if (sclk_rise && !packet_full) begin
							rx_shift_q <= {rx_shift_q[PKT_BITS-2:0], mosi_s}; // RULE1
							bit_cnt_q  <= bit_cnt_q + 6'd1;
							if (bit_cnt_q == 6'd31) state_q <= TMS_FULL;
						end
						if (sclk_fall) begin
							miso_q     <= tx_shift_q[PKT_BITS-1]; // RULE2
							tx_shift_q <= {tx_shift_q[PKT_BITS-2:0], 1'b0};
						end
					end
				end
				TMS_EXEC: begin
					// a new frame is not taken until execution ends
					if (busy_cnt_q != 3'd0) busy_cnt_q <= busy_cnt_q - 3'd1;
					if (exec_finish) state_q <= TMS_IDLE;
				end
				default: state_q <= TMS_IDLE;
			endcase
		end
	end

	// ************************************************************
	// output drivers: data enable, pacing line
	// ************************************************************
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			oe_q     <= 1'b0;
			done_n_q <= 1'b0;
		end else begin
			oe_q <= spi_mode & selected & (state_q != TMS_EXEC); // RULE4 RULE10
			if (sel_rise && state_q == TMS_FULL && spi_mode) begin
				done_n_q <= 1'b1; // RULE25
			end else if (exec_finish) begin
				done_n_q <= 1'b0; // RULE15
			end
		end
	end

	assign serial_data_out    = miso_q;
	assign serial_data_oe_out = oe_q;
	assign command_done_n_out = done_n_q;
	assign rx_packet_out      = rx_pkt_q;
	assign rx_packet_valid_out = rx_valid_q;
	assign interface_mode_out = mode_q;

	// ************************************************************
	// service request latch and alarm follower
	// ************************************************************
	// held active low so the pin comes straight from the flop
	logic srq_n_q;
	logic alarm_n_q;
	wire  err_now = comm_error_flag_in | exec_error_flag_in;

	// a fresh error in the clearing cycle wins over the clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			srq_n_q   <= 1'b1;
			alarm_n_q <= 1'b1;
		end else begin
			if (err_now && service_enable_in) begin
				srq_n_q <= 1'b0; // RULE17 RULE18
			end else if (status_clear_in || !service_enable_in) begin
				srq_n_q <= 1'b1; // RULE18
			end
			alarm_n_q <= ~(alarm_condition_in | (alarm_is_lock_in & tuning_active_in)); // RULE19 RULE20
		end
	end

	assign service_request_n_out = srq_n_q;
	assign condition_flag_n_out  = alarm_n_q;

	// ************************************************************
	// capability register
	// ************************************************************
	logic [CAP_WIDTH-1:0] cap_q;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			cap_q <= CAP_RESET; // RULE22
		end else begin
			cap_q <= {10'h000, MAX_RATE_MHZ}; // RULE21 RULE6
		end
	end
	assign interface_capability_out = cap_q;

	// ************************************************************
	// checks
	// ************************************************************
	chk_oe_select: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE4
		oe_q |-> $past(selected))
		else $error("serial output driven while deselected");
	chk_short_drop: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE12
		(sel_rise && state_q == TMS_SHIFT) |=> !rx_valid_q && state_q == TMS_IDLE)
		else $error("short packet not dropped");
	chk_exec_start: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE13
		rx_valid_q |-> $past(sel_rise) && $past(state_q) == TMS_FULL)
		else $error("packet released without select rise");
	chk_busy_high: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE25
		rx_valid_q |-> done_n_q)
		else $error("command done not busy at packet end");
	chk_done_low: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE15
		exec_finish |=> !done_n_q)
		else $error("command done not low after execution");
	chk_srq_set: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE17
		(err_now && service_enable_in) |=> !service_request_n_out)
		else $error("service request missed an error");
	chk_srq_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE18
		(!srq_n_q && !status_clear_in && service_enable_in) |=> !srq_n_q)
		else $error("service request dropped without clear");
	chk_alarm_tune: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE20
		(alarm_is_lock_in && tuning_active_in) |=> !condition_flag_n_out)
		else $error("alarm not held during tuning");
	chk_cap_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE21
		cap_q[15:6] == 10'h000)
		else $error("capability reserved bits not zero");
	chk_mode_frozen: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE9
		$past(mode_taken_q) |-> $stable(mode_q))
		else $error("interface mode changed after capture");
	cov_full_pkt: cover property (@(posedge core_clk_in) disable iff (rst_in) rx_valid_q);
	cov_abort: cover property (@(posedge core_clk_in) disable iff (rst_in)
		sel_rise && state_q == TMS_SHIFT);
	cov_srq: cover property (@(posedge core_clk_in) disable iff (rst_in)
		!srq_n_q && status_clear_in);
	cov_exec_end: cover property (@(posedge core_clk_in) disable iff (rst_in) exec_finish);
	cov_lock_tune: cover property (@(posedge core_clk_in) disable iff (rst_in)
		alarm_is_lock_in && tuning_active_in);
	// link side: capture and launch edges, packet count, mode gating
	chk_rise_capture: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE1
		(sclk_rise && state_q == TMS_SHIFT && spi_mode && !sel_rise)
		|=> rx_shift_q[0] == $past(mosi_s))
		else $error("incoming bit not taken on shift clock rise");
	chk_sel_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE23
		(sel_fall && spi_mode && state_q == TMS_IDLE)
		|=> miso_q == $past(tx_packet_in[PKT_BITS-1]))
		else $error("first outgoing bit not presented at select fall");
	chk_miso_edge: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE2
		$changed(miso_q) |-> $past(sclk_fall) || $past(sel_fall))
		else $error("serial output moved without a falling shift clock");
	chk_full_count: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE24
		(state_q == TMS_FULL) |-> bit_cnt_q == 6'd32)
		else $error("packet marked full before thirty two bits");
	chk_mode_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE8
		!spi_mode |=> !oe_q)
		else $error("serial output driven outside serial mode");
endmodule
`default_nettype wire

/* hw/tms_sync.sv */
// two flip-flop synchroniser for pins entering the core clock
`timescale 1ns/1ps
`default_nettype none
module tms_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("tms_sync width must be at least one");
	end

	// first stage feeds only the second stage
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* test/tb_tms_spi_slave.sv */
// self-checking bench for the tunable module serial slave port
`timescale 1ns/1ps
`default_nettype none
module tb_tms_spi_slave
	import tms_pkg::*;
;
	// 64 ns link period is 15.6 MHz, inside the 20 MHz reported here
	localparam logic [5:0] RATE = 6'h14;
	logic clk = 1'b0, rst = 1'b1, sclk, msn, mosi, miso, oe, sel0 = 1'b0, sel1 = 1'b0;
	logic done_n, srq_n, alm_n, rx_v, exec_done = 1'b0, ce = 1'b0, xe = 1'b0;
	logic sen = 1'b0, sclr = 1'b0, acond = 1'b0, alock = 1'b0, tune = 1'b0;
	logic [31:0] rx_pkt, tx_pkt = '0, hrx;
	logic [1:0] mode;
	logic [15:0] cap;
	int n_mismatch = 0, num_checks = 0, n_valid = 0, v0;
	// ************************************************************
	// clock, instances
	// ************************************************************
	always #2.5 clk = ~clk;
	tms_spi_slave #(.MAX_RATE_MHZ(RATE)) i_tms_spi_slave (.core_clk_in(clk), .rst_in(rst),
		.shift_clock_in(sclk), .module_select_n_in(msn), .serial_data_in(mosi),
		.serial_data_out(miso), .serial_data_oe_out(oe), .interface_select_0_in(sel0),
		.interface_select_1_in(sel1), .command_done_n_out(done_n),
		.service_request_n_out(srq_n), .condition_flag_n_out(alm_n),
		.rx_packet_out(rx_pkt), .rx_packet_valid_out(rx_v), .tx_packet_in(tx_pkt),
		.exec_done_in(exec_done), .comm_error_flag_in(ce), .exec_error_flag_in(xe),
		.service_enable_in(sen), .status_clear_in(sclr), .alarm_condition_in(acond),
		.alarm_is_lock_in(alock), .tuning_active_in(tune), .interface_mode_out(mode),
		.interface_capability_out(cap));
	tms_host_model i_tms_host_model (.miso_in(miso), .miso_oe_in(oe), .shift_clock_out(sclk),
		.module_select_n_out(msn), .mosi_out(mosi));
	// count packet pulses; a pulse stands one cycle
	always @(posedge clk) if (rx_v === 1'b1) n_valid <= n_valid + 1;
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] st);
		@(negedge clk) {sel1, sel0} = st;
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (12) @(negedge clk);
	endtask
	// bounded wait for command done to reach a level
	task automatic wait_done(input logic v);
		for (int i = 0; i < 40 && done_n !== v; i++) @(negedge clk);
		check("command_done_n", done_n, v);
	endtask
	task automatic exchange(input logic [31:0] host_d, input logic [31:0] dev_d,
		input int half_ns);
		@(negedge clk) tx_pkt = dev_d;
		v0 = n_valid;
		i_tms_host_model.frame(host_d, 32, half_ns, 80, hrx);
		check("host rx", hrx, dev_d);
		wait_done(1'b1);
		@(negedge clk); // pulse counter moves one edge after the pulse itself
		check("rx_packet", rx_pkt, host_d);
		check("valid pulses", n_valid - v0, 1);
		check("oe after frame", oe, 1'b0);
		@(negedge clk) exec_done = 1'b1;
		wait_done(1'b0);
		@(negedge clk) exec_done = 1'b0;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		do_reset(2'b00);
		check("capability", cap, {10'h000, RATE});
		check("idle pins", {done_n, srq_n, alm_n, oe}, 4'h6);
		@(negedge clk) {sel1, sel0} = 2'b11;
		repeat (10) @(negedge clk);
		check("mode after strap change", mode, IFSEL_SPI);
		{sel1, sel0} = 2'b00;
	endtask
	task automatic t_packets();
		exchange(32'h1234_5678, 32'hA5C3_0F1E, 32);
		// no-operation packet fetches status after a write
		exchange(32'h0000_0000, 32'h0000_0F0F, 32);
	endtask
	task automatic t_abort();
		v0 = n_valid;
		i_tms_host_model.frame(32'hFFFF_0000, 20, 32, 0, hrx);
		repeat (20) @(negedge clk);
		check("abort pulses", n_valid - v0, 0);
		check("abort done_n", done_n, 1'b0);
		exchange(32'h0BAD_F00D, 32'h8001_7FFE, 32);
	endtask
	// first contact at the guaranteed rate
	task automatic t_slow();
		exchange(32'hC3A5_5A3C, 32'h1357_9BDF, 500);
	endtask
	task automatic t_service();
		@(negedge clk) {sen, xe} = 2'b11;
		repeat (2) @(negedge clk);
		check("srq on error", srq_n, 1'b0);
		xe = 1'b0;
		repeat (5) @(negedge clk);
		check("srq latched", srq_n, 1'b0);
		{ce, sclr} = 2'b11;
		@(negedge clk) sclr = 1'b0;
		repeat (2) @(negedge clk);
		check("srq persists", srq_n, 1'b0);
		{ce, sclr} = 2'b01;
		@(negedge clk) sclr = 1'b0;
		repeat (2) @(negedge clk);
		check("srq cleared", srq_n, 1'b1);
		{sen, ce} = 2'b01;
		repeat (3) @(negedge clk);
		check("srq disabled", srq_n, 1'b1);
		ce = 1'b0;
	endtask
	task automatic t_alarm();
		logic [3:0] tbl [4];
		tbl = '{4'b1000, 4'b0001, 4'b0110, 4'b0101};
		// {condition, lock, tuning, expected level}
		foreach (tbl[i]) begin
			@(negedge clk) {acond, alock, tune} = tbl[i][3:1];
			repeat (2) @(negedge clk);
			check("condition_flag_n", alm_n, tbl[i][0]);
		end
		{acond, alock, tune} = 3'b000;
	endtask
	task automatic t_mode();
		do_reset(2'b01);
		check("mode async", mode, IFSEL_ASYNC);
		v0 = n_valid;
		i_tms_host_model.frame(32'h5555_AAAA, 32, 32, 0, hrx);
		repeat (20) @(negedge clk);
		check("no packet off mode", n_valid - v0, 0);
		do_reset(2'b11);
		check("mode vendor", mode, IFSEL_VENDOR);
		do_reset(2'b00);
		check("mode serial", mode, IFSEL_SPI);
	endtask
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		t_reset();
		t_slow();
		t_packets();
		t_abort();
		t_service();
		t_alarm();
		t_mode();
		complete_run();
	end
	// the slow frame alone takes about 32.5 us
	initial begin
		#150us;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire

/* test/tms_host_model.sv */
// host side master model: shift clock, select and outbound data
`timescale 1ns/1ps
`default_nettype none
module tms_host_model (
	input  wire logic miso_in,
	input  wire logic miso_oe_in,
	output var  logic shift_clock_out,
	output var  logic module_select_n_out,
	output var  logic mosi_out
);
	// ************************************************************
	// link state
	// ************************************************************
	logic last_q;
	// released line shows the inverse of the last bit, so a stale value cannot pass
	wire logic pin_w = miso_oe_in ? miso_in : ~last_q;
	// idle: clock low, not selected
	initial begin
		shift_clock_out = 1'b0;
		module_select_n_out = 1'b1;
		mosi_out = 1'b0;
		last_q = 1'b0;
	end
	// one frame, MSB first, byte gaps; half_ns sets the rate
	task automatic frame(input logic [31:0] tx_d, input int nbits, input int half_ns,
		input int gap_ns, output logic [31:0] rx_d);
		rx_d = '0;
		module_select_n_out = 1'b0;
		#100;
		for (int i = 0; i < nbits; i++) begin
			mosi_out = tx_d[31-i];
			#(half_ns) shift_clock_out = 1'b1;
			rx_d = {rx_d[30:0], pin_w};
			last_q = pin_w;
			#(half_ns) shift_clock_out = 1'b0;
			if (i % 8 == 7) #(gap_ns);
		end
		#40 mosi_out = ~mosi_out;
		module_select_n_out = 1'b1;
	endtask
endmodule
`default_nettype wire
